// ---- shared/sec_pkg.sv ----
// constants, types and register map of the selectable event counter bank
// Summary of operation
// - several counters; a pick register routes accesses
// - each counter counts only its chosen input
// - input choice off holds the value
// - acquisition, frame, row and shutter events count
// - io line counts edges or level cycles, qualified by sense
// - another counter's done pulse may be counted
// - timer done pulses may be counted
// - time base ticks may be counted
// - broadcast cue assertions may be counted
// - legacy line choice counts rising edges only
// - five senses: rise, fall, any, high, low
// - clear source: software, io line or cue
// - clear choice off: no hardware clear
// - clear input has its own sense
// - soft clear command clears, counting resumes
// - value before every clear is captured
// - current value readable and writable
// - at limit: done pulse, inactive, stopped
// - maximum count reports a readable wrap state
package sec_pkg;

  localparam int DATA_W = 32;
  localparam int ADR_W = 8;
  localparam int CHOICE_W = 8;
  localparam int ACQ_EVENTS = 10;

  // register byte offsets
  localparam logic [ADR_W-1:0] REG_PICK = 8'h00;
  localparam logic [ADR_W-1:0] REG_CNT_CHOICE = 8'h04;
  localparam logic [ADR_W-1:0] REG_CNT_SENSE = 8'h08;
  localparam logic [ADR_W-1:0] REG_CLR_CHOICE = 8'h0c;
  localparam logic [ADR_W-1:0] REG_CLR_SENSE = 8'h10;
  localparam logic [ADR_W-1:0] REG_SOFT_CLEAR = 8'h14;
  localparam logic [ADR_W-1:0] REG_COUNT_NOW = 8'h18;
  localparam logic [ADR_W-1:0] REG_BEFORE_CLEAR = 8'h1c;
  localparam logic [ADR_W-1:0] REG_LIMIT = 8'h20;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h24;

  // input choice codes: group in the high nibble, index in the low one
  localparam logic [CHOICE_W-1:0] SRC_OFF = 8'h00;
  localparam logic [CHOICE_W-1:0] SRC_ACQ_FIRST = 8'h01;
  localparam logic [CHOICE_W-1:0] CLR_SOFT = 8'h01;
  localparam logic [3:0] GRP_ACQ = 4'h0;
  localparam logic [3:0] GRP_LINE = 4'h1;
  localparam logic [3:0] GRP_CNT_END = 4'h2;
  localparam logic [3:0] GRP_TIMER = 4'h3;
  localparam logic [3:0] GRP_TICK = 4'h4;
  localparam logic [3:0] GRP_CUE = 4'h5;
  localparam logic [3:0] GRP_LINE_RISE = 4'h6;

  typedef enum logic [2:0] {
    SENSE_RISE = 3'h0,
    SENSE_FALL = 3'h1,
    SENSE_ANY = 3'h2,
    SENSE_HIGH = 3'h3,
    SENSE_LOW = 3'h4
  } sec_sense_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_DONE = 4'h4,
    ST_WRAP = 4'h8
  } sec_state_t;

  // internal acquisition events, one-cycle pulses; code 1 is acqGo
  typedef struct packed {
    logic shutterClose;
    logic shutterOpen;
    logic rowEnd;
    logic rowBegin;
    logic imageEnd;
    logic imageBegin;
    logic frameGo;
    logic acqEnd;
    logic acqBegin;
    logic acqGo;
  } sec_acq_evt_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } sec_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] dat;
  } sec_wb_rsp_t;

endpackage : sec_pkg

// ---- verilog/sec_source_mux.sv ----
// picks one input signal for a counter from its choice code
module sec_source_mux #(
  parameter int NLINE = 4,
  parameter int NCNT = 4,
  parameter int NTIMER = 2,
  parameter int NCUE = 2
) (
  input wire logic [sec_pkg::CHOICE_W-1:0] choice,
  input wire sec_pkg::sec_acq_evt_t acqEvt,
  input wire logic [NLINE-1:0] ioLine,
  input wire logic [NCNT-1:0] cntDone,
  input wire logic [NTIMER-1:0] timerDone,
  input wire logic timeBaseTick,
  input wire logic [NCUE-1:0] broadcastCue,
  output logic sig,
  output logic forceRise
);

  logic [3:0] grp;
  logic [3:0] idx;
  logic [sec_pkg::ACQ_EVENTS-1:0] acqVec;

  assign grp = choice[7:4];
  assign idx = choice[3:0];
  assign acqVec = acqEvt;

  always_comb begin
    sig = 1'b0;
    forceRise = 1'b0;
    case (grp)
      sec_pkg::GRP_ACQ: begin
        for (int i = 0; i < sec_pkg::ACQ_EVENTS; i++) begin
          if (choice == sec_pkg::SRC_ACQ_FIRST + 8'(i)) sig = acqVec[i];
        end
      end
      sec_pkg::GRP_LINE: begin
        for (int i = 0; i < NLINE; i++) begin
          if (idx == 4'(i)) sig = ioLine[i];
        end
      end
      sec_pkg::GRP_CNT_END: begin
        for (int i = 0; i < NCNT; i++) begin
          if (idx == 4'(i)) sig = cntDone[i];
        end
      end
      sec_pkg::GRP_TIMER: begin
        for (int i = 0; i < NTIMER; i++) begin
          if (idx == 4'(i)) sig = timerDone[i];
        end
      end
      sec_pkg::GRP_TICK: sig = timeBaseTick;
      sec_pkg::GRP_CUE: begin
        for (int i = 0; i < NCUE; i++) begin
          if (idx == 4'(i)) sig = broadcastCue[i];
        end
      end
      sec_pkg::GRP_LINE_RISE: begin
        for (int i = 0; i < NLINE; i++) if (idx == 4'(i)) sig = ioLine[i];
        forceRise = 1'b1;
      end
      default: sig = 1'b0;
    endcase
  end

endmodule : sec_source_mux

// ---- verilog/sec_sense.sv ----
// qualifies a selected signal by edge or level sense
module sec_sense (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sig,
  input wire sec_pkg::sec_sense_t mode,
  input wire logic forceRise,
  output logic hit
);

  logic prevQ;

  // the previous sample is what edges are measured against
  always_ff @(posedge clk) begin
    if (sys_rst) prevQ <= 1'b0;
    else prevQ <= sig;
  end

  always_comb begin
    if (forceRise) hit = sig & ~prevQ;
    else begin
      case (mode)
        sec_pkg::SENSE_RISE: hit = sig & ~prevQ;
        sec_pkg::SENSE_FALL: hit = ~sig & prevQ;
        sec_pkg::SENSE_ANY: hit = sig ^ prevQ;
        sec_pkg::SENSE_HIGH: hit = sig;
        sec_pkg::SENSE_LOW: hit = ~sig;
        default: hit = 1'b0;
      endcase
    end
  end

endmodule : sec_sense

// ---- verilog/sec_counter_bank.sv ----
// bank of event counters with a classic wishbone register slave
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
module sec_counter_bank #(
  parameter int NCNT = 4,
  parameter int NLINE = 4,
  parameter int NTIMER = 2,
  parameter int NCUE = 2,
  parameter int CW = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire sec_pkg::sec_wb_req_t wbReq,
  output sec_pkg::sec_wb_rsp_t wbRsp,
  input wire sec_pkg::sec_acq_evt_t acqEvt,
  input wire logic [NLINE-1:0] ioLine,
  input wire logic [NTIMER-1:0] timerDonePulse,
  input wire logic timeBaseTick,
  input wire logic [NCUE-1:0] broadcastCue,
  output logic [NCNT-1:0] countDonePulse,
  output logic [NCNT-1:0] countingFlag
);

  localparam logic [CW-1:0] COUNT_MAX = {CW{1'b1}};
  localparam logic [CW-1:0] COUNT_ONE = CW'(1);

  // bus side
  logic ackQ;
  logic [sec_pkg::DATA_W-1:0] rdatQ;
  logic [sec_pkg::DATA_W-1:0] rdatD;
  logic busReq;
  logic wrEn;
  logic [5:0] wordAdr;

  // per-counter configuration and state
  logic [7:0] pickQ;
  logic [sec_pkg::CHOICE_W-1:0] cntChoiceQ [NCNT];
  logic [sec_pkg::CHOICE_W-1:0] clrChoiceQ [NCNT];
  sec_pkg::sec_sense_t cntSenseQ [NCNT];
  sec_pkg::sec_sense_t clrSenseQ [NCNT];
  logic [CW-1:0] limitQ [NCNT];
  logic [CW-1:0] valueQ [NCNT];
  logic [CW-1:0] beforeQ [NCNT];
  sec_pkg::sec_state_t stateQ [NCNT];
  sec_pkg::sec_state_t stateD [NCNT];
  logic [NCNT-1:0] doneQ;

  // per-counter events of this cycle
  logic [NCNT-1:0] cntSig;
  logic [NCNT-1:0] cntRise;
  logic [NCNT-1:0] cntHit;
  logic [NCNT-1:0] clrSig;
  logic [NCNT-1:0] clrHit;
  logic [NCNT-1:0] picked;
  logic [NCNT-1:0] incr;
  logic [NCNT-1:0] atLimit;
  logic [NCNT-1:0] atMax;
  logic [NCNT-1:0] clearNow;
  logic [NCNT-1:0] loadNow;

  function automatic logic [sec_pkg::DATA_W-1:0] merge(
    input logic [sec_pkg::DATA_W-1:0] old,
    input logic [sec_pkg::DATA_W-1:0] upd,
    input logic [3:0] sel
  );
    logic [sec_pkg::DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) res[b*8 +: 8] = upd[b*8 +: 8];
    end
    return res;
  endfunction : merge

  function automatic logic hitAdr(
    input logic [5:0] wa,
    input logic [sec_pkg::ADR_W-1:0] reg_adr
  );
    return wa == reg_adr[sec_pkg::ADR_W-1:2];
  endfunction : hitAdr

  // a request is answered one cycle after it appears; writes land on
  // the edge where the master sees ack, so none is applied twice
  assign busReq = wbReq.cyc & wbReq.stb;
  assign wrEn = busReq & wbReq.we & ackQ;
  assign wordAdr = wbReq.adr[sec_pkg::ADR_W-1:2];

  always_ff @(posedge clk) begin
    if (sys_rst) ackQ <= 1'b0;
    else ackQ <= busReq & ~ackQ;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) rdatQ <= '0;
    else if (busReq & ~ackQ) rdatQ <= rdatD;
  end

  assign wbRsp.ack = ackQ;
  assign wbRsp.dat = rdatQ;

  always_ff @(posedge clk) begin
    if (sys_rst) pickQ <= '0;
    else if (wrEn && hitAdr(wordAdr, sec_pkg::REG_PICK) && wbReq.sel[0]) begin
      pickQ <= wbReq.dat[7:0];
    end
  end

  always_comb begin
    for (int i = 0; i < NCNT; i++) picked[i] = pickQ == 8'(i);
  end

  // input selection and qualification for every counter
  genvar g;
  generate
    for (g = 0; g < NCNT; g++) begin : gCnt
      sec_source_mux #(
        .NLINE(NLINE),
        .NCNT(NCNT),
        .NTIMER(NTIMER),
        .NCUE(NCUE)
      ) uCntMux (
        .choice(cntChoiceQ[g]),
        .acqEvt(acqEvt),
        .ioLine(ioLine),
        .cntDone(doneQ),
        .timerDone(timerDonePulse),
        .timeBaseTick(timeBaseTick),
        .broadcastCue(broadcastCue),
        .sig(cntSig[g]),
        .forceRise(cntRise[g])
      );

      sec_sense uCntSense (
        .clk(clk),
        .sys_rst(sys_rst),
        .sig(cntSig[g]),
        .mode(cntSenseQ[g]),
        .forceRise(cntRise[g]),
        .hit(cntHit[g])
      );

      // clear choices reuse the count codes; only line and cue groups act
      sec_source_mux #(
        .NLINE(NLINE),
        .NCNT(NCNT),
        .NTIMER(NTIMER),
        .NCUE(NCUE)
      ) uClrMux (
        .choice(clrChoiceQ[g]),
        .acqEvt('0),
        .ioLine(ioLine),
        .cntDone('0),
        .timerDone('0),
        .timeBaseTick(1'b0),
        .broadcastCue(broadcastCue),
        .sig(clrSig[g]),
        .forceRise()
      );

      sec_sense uClrSense (
        .clk(clk),
        .sys_rst(sys_rst),
        .sig(clrSig[g]),
        .mode(clrSenseQ[g]),
        .forceRise(1'b0),
        .hit(clrHit[g])
      );
    end
  endgenerate

  // clear and load conditions
  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      logic [3:0] grp;
      logic hw;
      grp = clrChoiceQ[i][7:4];
      hw = (grp == sec_pkg::GRP_LINE) | (grp == sec_pkg::GRP_CUE);
      // off and software-only choices never clear from a pin
      clearNow[i] = (hw & clrHit[i])
        | (wrEn & picked[i] & hitAdr(wordAdr, sec_pkg::REG_SOFT_CLEAR));
      loadNow[i] = wrEn & picked[i]
        & hitAdr(wordAdr, sec_pkg::REG_COUNT_NOW);
    end
  end

  // increment only while running on a qualified event of the choice
  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      incr[i] = cntHit[i] & (cntChoiceQ[i] != sec_pkg::SRC_OFF)
        & (stateQ[i] == sec_pkg::ST_RUN);
      atLimit[i] = (limitQ[i] != '0)
        & (valueQ[i] + COUNT_ONE == limitQ[i]);
      atMax[i] = valueQ[i] + COUNT_ONE == COUNT_MAX;
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCNT; i++) begin
        cntChoiceQ[i] <= sec_pkg::SRC_OFF;
        clrChoiceQ[i] <= sec_pkg::SRC_OFF;
      end
    end else if (wrEn && wbReq.sel[0]) begin
      for (int i = 0; i < NCNT; i++) begin
        if (picked[i] && hitAdr(wordAdr, sec_pkg::REG_CNT_CHOICE)) begin
          cntChoiceQ[i] <= wbReq.dat[7:0];
        end
        if (picked[i] && hitAdr(wordAdr, sec_pkg::REG_CLR_CHOICE)) begin
          clrChoiceQ[i] <= wbReq.dat[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCNT; i++) begin
        cntSenseQ[i] <= sec_pkg::SENSE_RISE;
        clrSenseQ[i] <= sec_pkg::SENSE_RISE;
      end
    end else if (wrEn && wbReq.sel[0]) begin
      for (int i = 0; i < NCNT; i++) begin
        if (picked[i] && hitAdr(wordAdr, sec_pkg::REG_CNT_SENSE)) begin
          cntSenseQ[i] <= sec_pkg::sec_sense_t'(wbReq.dat[2:0]);
        end
        if (picked[i] && hitAdr(wordAdr, sec_pkg::REG_CLR_SENSE)) begin
          clrSenseQ[i] <= sec_pkg::sec_sense_t'(wbReq.dat[2:0]);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCNT; i++) limitQ[i] <= '0;
    end else if (wrEn && hitAdr(wordAdr, sec_pkg::REG_LIMIT)) begin
      for (int i = 0; i < NCNT; i++) begin
        if (picked[i]) begin
          limitQ[i] <= CW'(merge(sec_pkg::DATA_W'(limitQ[i]),
                                 wbReq.dat, wbReq.sel));
        end
      end
    end
  end

  // counting: a clear outranks a load, a load outranks an increment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCNT; i++) valueQ[i] <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (clearNow[i]) valueQ[i] <= '0;
        else if (loadNow[i]) begin
          valueQ[i] <= CW'(merge(sec_pkg::DATA_W'(valueQ[i]),
                                 wbReq.dat, wbReq.sel));
        end else if (incr[i]) valueQ[i] <= valueQ[i] + COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCNT; i++) beforeQ[i] <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (clearNow[i]) beforeQ[i] <= valueQ[i];
      end
    end
  end

  // run state of each counter
  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      logic off;
      off = cntChoiceQ[i] == sec_pkg::SRC_OFF;
      stateD[i] = stateQ[i];
      if (clearNow[i] | loadNow[i]) begin
        // a clear or load restarts at once unless the input is off
        stateD[i] = off ? sec_pkg::ST_IDLE : sec_pkg::ST_RUN;
      end else begin
        case (stateQ[i])
          sec_pkg::ST_IDLE: if (!off) stateD[i] = sec_pkg::ST_RUN;
          sec_pkg::ST_RUN: begin
            if (off) stateD[i] = sec_pkg::ST_IDLE;
            else if (incr[i] & atLimit[i]) stateD[i] = sec_pkg::ST_DONE;
            else if (incr[i] & atMax[i]) stateD[i] = sec_pkg::ST_WRAP;
          end
          sec_pkg::ST_DONE: stateD[i] = sec_pkg::ST_DONE;
          sec_pkg::ST_WRAP: stateD[i] = sec_pkg::ST_WRAP;
          default: stateD[i] = sec_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCNT; i++) stateQ[i] <= sec_pkg::ST_IDLE;
    end else begin
      for (int i = 0; i < NCNT; i++) stateQ[i] <= stateD[i];
    end
  end

  // the done pulse is registered, so cascading never loops combinationally
  always_ff @(posedge clk) begin
    if (sys_rst) doneQ <= '0;
    else begin
      for (int i = 0; i < NCNT; i++) begin
        doneQ[i] <= incr[i] & atLimit[i] & ~clearNow[i] & ~loadNow[i];
      end
    end
  end

  assign countDonePulse = doneQ;

  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      countingFlag[i] = stateQ[i] == sec_pkg::ST_RUN;
    end
  end

  // read data for the picked counter; unmapped words read zero
  always_comb begin
    rdatD = '0;
    if (hitAdr(wordAdr, sec_pkg::REG_PICK)) rdatD[7:0] = pickQ;
    for (int i = 0; i < NCNT; i++) begin
      if (picked[i]) begin
        case (wordAdr)
          sec_pkg::REG_CNT_CHOICE[7:2]: rdatD[7:0] = cntChoiceQ[i];
          sec_pkg::REG_CNT_SENSE[7:2]: rdatD[2:0] = cntSenseQ[i];
          sec_pkg::REG_CLR_CHOICE[7:2]: rdatD[7:0] = clrChoiceQ[i];
          sec_pkg::REG_CLR_SENSE[7:2]: rdatD[2:0] = clrSenseQ[i];
          sec_pkg::REG_COUNT_NOW[7:2]: begin
            rdatD = sec_pkg::DATA_W'(valueQ[i]);
          end
          sec_pkg::REG_BEFORE_CLEAR[7:2]: begin
            rdatD = sec_pkg::DATA_W'(beforeQ[i]);
          end
          sec_pkg::REG_LIMIT[7:2]: rdatD = sec_pkg::DATA_W'(limitQ[i]);
          sec_pkg::REG_STATUS[7:2]: rdatD[3:0] = stateQ[i];
          default: ;
        endcase
      end
    end
  end

endmodule : sec_counter_bank

// ---- test/sec_counter_bank_properties.sv ----
// concurrent checks on the counter bank ports
module sec_counter_bank_properties #(
  parameter int NCNT = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire sec_pkg::sec_wb_req_t wbReq,
  input wire sec_pkg::sec_wb_rsp_t wbRsp,
  input wire logic [NCNT-1:0] countDonePulse,
  input wire logic [NCNT-1:0] countingFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic newReq;
  assign newReq = wbReq.cyc && wbReq.stb && !wbRsp.ack;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_ack_follows_req: assert property (newReq |=> wbRsp.ack)
    else $error("ack missing one cycle after a request");
  a_ack_one_cycle: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property (!newReq |=> !wbRsp.ack)
    else $error("ack without a request");
  a_unmapped_zero: assert property (newReq && !wbReq.we &&
    wbReq.adr >= 8'h28 |=> wbRsp.dat == '0)
    else $error("unmapped read returned nonzero data");
  a_done_not_counting: assert property (
    (countDonePulse & countingFlag) == '0)
    else $error("counter still active while its done pulse shows");
  a_done_from_run: assert property (countDonePulse != '0 |->
    (countDonePulse & ~$past(countingFlag)) == '0)
    else $error("done pulse from a counter that was not running");
  a_done_single: assert property (countDonePulse != '0 |=>
    (countDonePulse & $past(countDonePulse)) == '0)
    else $error("done pulse longer than one cycle");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !wbRsp.ack &&
    countDonePulse == '0 && countingFlag == '0)
    else $error("outputs not quiet after reset");

  c_write: cover property (newReq && wbReq.we);
  c_done: cover property (countDonePulse != '0);
  c_stop: cover property ($fell(countingFlag[0]));
endmodule : sec_counter_bank_properties

// ---- test/sec_event_model.sv ----
// far-side model: acquisition events, io lines, timers, ticks, cues
module sec_event_model (
  input wire logic clk,
  output sec_pkg::sec_acq_evt_t acqEvt,
  output logic [3:0] ioLine,
  output logic [1:0] timerDonePulse,
  output logic timeBaseTick,
  output logic [1:0] broadcastCue
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    acqEvt = '0;
    ioLine = '0;
    timerDonePulse = '0;
    timeBaseTick = 1'b0;
    broadcastCue = '0;
  end

  task automatic setLine(input int idx, input logic v);
    @(posedge clk);
    ioLine[idx] <= v;
  endtask : setLine

  // pulses last one cycle; a line is inverted for three cycles, then restored
  task automatic pulse(input int kind, input int idx);
    @(posedge clk);
    case (kind)
      0: acqEvt[idx] <= 1'b1;
      1: ioLine[idx] <= !ioLine[idx];
      2: timerDonePulse[idx] <= 1'b1;
      3: timeBaseTick <= 1'b1;
      4: broadcastCue[idx] <= 1'b1;
      default: ;
    endcase
    if (kind == 1) repeat (2) @(posedge clk);
    @(posedge clk);
    if (kind == 1) ioLine[idx] <= !ioLine[idx];
    acqEvt <= '0;
    timerDonePulse <= '0;
    timeBaseTick <= 1'b0;
    broadcastCue <= '0;
  endtask : pulse
endmodule : sec_event_model

// ---- test/test_selectable_event_counter_bank.sv ----
// self-checking bench for the counter bank
module test_selectable_event_counter_bank;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] ch;
    logic [2:0] se;
    int kind;
    int idx;
    logic [31:0] exp;
  } sec_case_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  sec_pkg::sec_wb_req_t wbReq = '0;
  sec_pkg::sec_wb_rsp_t wbRsp;
  sec_pkg::sec_acq_evt_t acqEvt;
  logic [3:0] ioLine;
  logic [1:0] timerDonePulse;
  logic timeBaseTick;
  logic [1:0] broadcastCue;
  logic [3:0] countDonePulse;
  logic [3:0] countingFlag;
  logic [31:0] rd;
  int errorCnt = 0;
  int compares = 0;
  int doneSeen = 0;
  // line rows: low sense idles the line high; legacy code ignores any-edge
  sec_case_t rows [12] = '{'{8'h10, 3'h0, 1, 0, 32'h1},
    '{8'h10, 3'h1, 1, 0, 32'h1}, '{8'h10, 3'h2, 1, 0, 32'h2},
    '{8'h10, 3'h3, 1, 0, 32'h3}, '{8'h10, 3'h4, 1, 0, 32'h3},
    '{8'h60, 3'h2, 1, 0, 32'h1}, '{8'h31, 3'h0, 2, 1, 32'h1},
    '{8'h40, 3'h0, 3, 0, 32'h1}, '{8'h51, 3'h0, 4, 1, 32'h1},
    '{8'h00, 3'h0, 1, 0, 32'h0}, '{8'h12, 3'h0, 1, 0, 32'h0},
    '{8'h50, 3'h0, 4, 1, 32'h0}};

  always #5 clk = ~clk;

  // done pulses of counter 0, looked at mid-cycle where they are settled
  always @(negedge clk) begin
    if (countDonePulse[0]) doneSeen++;
  end

  sec_counter_bank i_dut (.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq),
    .wbRsp(wbRsp), .acqEvt(acqEvt), .ioLine(ioLine),
    .timerDonePulse(timerDonePulse), .timeBaseTick(timeBaseTick),
    .broadcastCue(broadcastCue), .countDonePulse(countDonePulse),
    .countingFlag(countingFlag));
  sec_event_model i_src (.clk(clk), .acqEvt(acqEvt), .ioLine(ioLine),
    .timerDonePulse(timerDonePulse), .timeBaseTick(timeBaseTick),
    .broadcastCue(broadcastCue));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (errorCnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk);
    end while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : chk_rd

  task automatic run_case(input sec_case_t c);
    i_src.setLine(0, c.se == 3'h4);
    wr(sec_pkg::REG_CNT_SENSE, {29'h0, c.se});
    wr(sec_pkg::REG_CNT_CHOICE, {24'h0, c.ch});
    wr(sec_pkg::REG_COUNT_NOW, 32'h0);
    i_src.pulse(c.kind, c.idx);
    repeat (4) @(posedge clk);
    chk_rd(sec_pkg::REG_COUNT_NOW, c.exp);
  endtask : run_case

  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk_rd(sec_pkg::REG_PICK, 32'h0);
    chk_rd(sec_pkg::REG_CNT_CHOICE, 32'h0);
    chk_rd(sec_pkg::REG_LIMIT, 32'h0);
    chk_rd(sec_pkg::REG_STATUS, 32'h1);
    foreach (rows[i]) run_case(rows[i]);
    for (int i = 0; i < 10; i++) begin
      run_case('{8'h01 + i[7:0], 3'h0, 0, i, 32'h1});
    end
    // cascade: counter 1 counts the done pulses of counter 0
    wr(sec_pkg::REG_CNT_CHOICE, 8'h10);
    wr(sec_pkg::REG_LIMIT, 32'h2);
    wr(sec_pkg::REG_COUNT_NOW, 32'h0);
    wr(sec_pkg::REG_PICK, 32'h1);
    wr(sec_pkg::REG_CNT_CHOICE, 8'h20);
    wr(sec_pkg::REG_COUNT_NOW, 32'h0);
    repeat (3) i_src.pulse(1, 0);
    check({30'h0, countingFlag[1:0]}, 32'h2);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'h1);
    check(doneSeen, 32'h1);
    wr(sec_pkg::REG_PICK, 32'h0);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'h2);
    chk_rd(sec_pkg::REG_STATUS, 32'h4);
    // wrap at all ones, then a soft clear restarts it
    wr(sec_pkg::REG_PICK, 32'h1);
    wr(sec_pkg::REG_CNT_CHOICE, 8'h40);
    wr(sec_pkg::REG_COUNT_NOW, 32'hffff_fffe);
    repeat (2) i_src.pulse(3, 0);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'hffff_ffff);
    chk_rd(sec_pkg::REG_STATUS, 32'h8);
    wr(sec_pkg::REG_SOFT_CLEAR, 32'h0);
    chk_rd(sec_pkg::REG_BEFORE_CLEAR, 32'hffff_ffff);
    i_src.pulse(3, 0);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'h1);
    chk_rd(sec_pkg::REG_STATUS, 32'h2);
    // counter 0: clear and count on the same line edge, then a clear on a cue fall, then clear choice off
    wr(sec_pkg::REG_PICK, 32'h0);
    wr(sec_pkg::REG_LIMIT, 32'h0);
    wr(sec_pkg::REG_CLR_CHOICE, 8'h10);
    wr(sec_pkg::REG_COUNT_NOW, 32'h4);
    i_src.pulse(1, 0);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'h0);
    chk_rd(sec_pkg::REG_BEFORE_CLEAR, 32'h4);
    wr(sec_pkg::REG_CLR_CHOICE, 8'h50);
    wr(sec_pkg::REG_CLR_SENSE, 32'h1);
    wr(sec_pkg::REG_COUNT_NOW, 32'h9);
    i_src.pulse(4, 0);
    chk_rd(sec_pkg::REG_BEFORE_CLEAR, 32'h9);
    wr(sec_pkg::REG_CLR_CHOICE, 8'h00);
    wr(sec_pkg::REG_COUNT_NOW, 32'h3);
    i_src.pulse(4, 0);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'h3);
    chk_rd(8'h40, 32'h0);
    wr(sec_pkg::REG_PICK, 32'h4);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'h0);
    // a reset in mid-run must bring pick, count and status back to their reset values
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk_rd(sec_pkg::REG_PICK, 32'h0);
    chk_rd(sec_pkg::REG_COUNT_NOW, 32'h0);
    chk_rd(sec_pkg::REG_STATUS, 32'h1);
    end_of_test;
  end
endmodule : test_selectable_event_counter_bank

bind sec_counter_bank sec_counter_bank_properties #(.NCNT(NCNT)) i_props (
  .clk(clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
  .countDonePulse(countDonePulse), .countingFlag(countingFlag));
